// ---- hw/cmibs_pkg.sv ----
// Overview of operation
// - Mode bit 12 is the global gate: 0 blocks every maskable interrupt.
// - Dispatch needs both the global gate and the interrupt's own unmask.
// - Nesting bit 11 clear: a running handler is never preempted.
// - Nesting off: arrivals latch, dispatch after active handler returns.
// - Nesting on: higher priority request preempts lower priority handler.
// - Nesting on: lower priority arrivals wait for all higher priority handlers.
// - Bit 10 selects secondary bank for data regs 0-7 of both elements.
// - Bit 7 selects secondary bank for data regs 8-15 of both elements.
// - Bit 6 selects secondary bank for generator two regs 8-11.
// - Bit 5 selects secondary bank for generator two regs 12-15.
// - Bit 4 selects secondary bank for generator one regs 0-3.
// - Bit 3 selects secondary bank for generator one regs 4-7.
`default_nettype none

package cmibs_pkg;

  localparam int unsigned CMIBS_ADDR_W   = 8;
  localparam int unsigned CMIBS_DATA_W   = 32;
  localparam int unsigned CMIBS_NUM_IRQ  = 8;
  localparam int unsigned CMIBS_IDX_W    = 3;
  localparam int unsigned CMIBS_NUM_BANK = 6;

  localparam logic [7:0]  CMIBS_MODE_OFS = 8'h00;
  localparam logic [7:0]  CMIBS_STAT_OFS = 8'h04;
  localparam logic [31:0] CMIBS_MODE_RST = 32'h00000000;

  localparam int unsigned CMIBS_IRQ_GATE_BIT = 12;
  localparam int unsigned CMIBS_NEST_BIT     = 11;
  localparam int unsigned CMIBS_DR_LOW_BIT   = 10;
  localparam int unsigned CMIBS_DR_HIGH_BIT  = 7;
  localparam int unsigned CMIBS_A2_LOW_BIT   = 6;
  localparam int unsigned CMIBS_A2_HIGH_BIT  = 5;
  localparam int unsigned CMIBS_A1_LOW_BIT   = 4;
  localparam int unsigned CMIBS_A1_HIGH_BIT  = 3;

  // Bank select vector index i maps to mode bit CMIBS_BANK_BIT[i]
  localparam int unsigned CMIBS_BANK_BIT [CMIBS_NUM_BANK] = '{
    CMIBS_A1_HIGH_BIT, CMIBS_A1_LOW_BIT, CMIBS_A2_HIGH_BIT,
    CMIBS_A2_LOW_BIT, CMIBS_DR_HIGH_BIT, CMIBS_DR_LOW_BIT};

  localparam logic [31:0] CMIBS_MODE_MASK = 32'h00001CF8;

  localparam int unsigned CMIBS_STAT_PEND_LSB = 0;
  localparam int unsigned CMIBS_STAT_ACT_LSB  = 8;

  typedef struct packed {
    logic [CMIBS_ADDR_W-1:0] addr;
    logic [CMIBS_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } cmibs_bus_req_s;

  // Field order matches bank vector index 5 down to 0
  typedef struct packed {
    logic data_regs_low_bank_sel;
    logic data_regs_high_bank_sel;
    logic agen_two_low_bank_sel;
    logic agen_two_high_bank_sel;
    logic agen_one_low_bank_sel;
    logic agen_one_high_bank_sel;
  } cmibs_bank_sel_s;

  typedef struct packed {
    logic [CMIBS_DATA_W-1:0]  mode;
    logic [CMIBS_NUM_IRQ-1:0] pend;
    logic [CMIBS_NUM_IRQ-1:0] act;
    logic [CMIBS_DATA_W-1:0]  rdata;
    logic                     disp;
    logic [CMIBS_IDX_W-1:0]   vec;
  } cmibs_state_s;

endpackage : cmibs_pkg

`default_nettype wire

// ---- hw/cmibs_mode_ctrl.sv ----
// Implementation choices: the strobed register port and the address map.
`default_nettype none

module cmibs_mode_ctrl
  import cmibs_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire cmibs_bus_req_s           bus_req,
  output logic [CMIBS_DATA_W-1:0]       bus_rdata,
  input  wire logic [CMIBS_NUM_IRQ-1:0] irq_raise,
  input  wire logic [CMIBS_NUM_IRQ-1:0] irq_unmask,
  input  wire logic                     isr_return,
  output logic                          irq_dispatch,
  output logic [CMIBS_IDX_W-1:0]        irq_dispatch_vec,
  output logic                          irq_in_service,
  output logic                          global_maskable_irq_gate,
  output logic                          irq_nesting_allow,
  output cmibs_bank_sel_s               bank_sel
);

  cmibs_state_s cur_reg;
  cmibs_state_s cur_next;

  logic [CMIBS_NUM_BANK-1:0] bank_vec;
  logic [CMIBS_NUM_IRQ-1:0]  eligible;
  logic [CMIBS_NUM_IRQ-1:0]  cand;
  logic [CMIBS_NUM_IRQ-1:0]  below_top;
  logic [CMIBS_NUM_IRQ-1:0]  disp_onehot;
  logic [CMIBS_NUM_IRQ-1:0]  ret_onehot;
  logic [CMIBS_DATA_W-1:0]   status_word;
  logic                      top_valid;
  logic                      cand_valid;
  logic [CMIBS_IDX_W-1:0]    cand_idx;
  logic [CMIBS_NUM_IRQ-1:0]  pend_nxt;
  logic [CMIBS_NUM_IRQ-1:0]  act_nxt;
  logic [CMIBS_NUM_IRQ-1:0]  stat_clr;
  logic [CMIBS_NUM_IRQ-1:0]  retire;
  logic [CMIBS_NUM_IRQ:0]    act_seen;
  logic [CMIBS_NUM_IRQ:0]    cand_seen;

  // Lowest index wins: index 0 is the highest priority
  function automatic logic [CMIBS_IDX_W-1:0] lowest_idx(
    input logic [CMIBS_NUM_IRQ-1:0] v
  );
    logic [CMIBS_IDX_W-1:0] r;
    r = '0;
    for (int i = CMIBS_NUM_IRQ - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = CMIBS_IDX_W'(i);
      end
    end
    return r;
  endfunction

  // Prefix chains make index 0 the highest priority without a wide mux
  assign act_seen[0]  = 1'b0;
  assign cand_seen[0] = 1'b0;

  assign stat_clr = (bus_req.wr && (bus_req.addr == CMIBS_STAT_OFS))
                  ? bus_req.wdata[CMIBS_STAT_PEND_LSB +: CMIBS_NUM_IRQ]
                  : '0;

  generate
    for (genvar s = 0; s < CMIBS_NUM_IRQ; s++)
    begin : g_src
      assign eligible[s] = cur_reg.pend[s]
                         & irq_unmask[s]
                         & cur_reg.mode[CMIBS_IRQ_GATE_BIT];

      // Innermost handler is the lowest active index
      assign act_seen[s+1] = act_seen[s] | cur_reg.act[s];
      assign ret_onehot[s] = cur_reg.act[s] & ~act_seen[s];
      assign below_top[s]  = ~act_seen[s+1];

      assign cand_seen[s+1] = cand_seen[s] | cand[s];
      assign disp_onehot[s] = cand[s] & ~cand_seen[s];

      // A return and a dispatch in one cycle hit different indices
      assign retire[s]  = ret_onehot[s] & isr_return;
      assign act_nxt[s] = (cur_reg.act[s] & ~retire[s]) | disp_onehot[s];

      // Arrivals latch while blocked; a new raise beats any clear
      assign pend_nxt[s] = irq_raise[s]
                         | (cur_reg.pend[s] & ~disp_onehot[s] & ~stat_clr[s]);
    end
  endgenerate

  always_comb
  begin
    top_valid = |cur_reg.act;

    if (!top_valid)
    begin
      cand = eligible;
    end
    else if (cur_reg.mode[CMIBS_NEST_BIT])
    begin
      // Only strictly higher priority than the innermost handler
      cand = eligible & below_top;
    end
    else
    begin
      cand = '0;
    end

    cand_valid  = |cand;
    cand_idx    = lowest_idx(cand);

    status_word = '0;
    status_word[CMIBS_STAT_PEND_LSB +: CMIBS_NUM_IRQ] = cur_reg.pend;
    status_word[CMIBS_STAT_ACT_LSB +: CMIBS_NUM_IRQ]  = cur_reg.act;
  end

  always_comb
  begin
    cur_next       = cur_reg;
    cur_next.disp  = cand_valid;
    cur_next.vec   = cand_valid ? cand_idx : cur_reg.vec;
    cur_next.rdata = '0;

    if (bus_req.wr && (bus_req.addr == CMIBS_MODE_OFS))
    begin
      // Bits outside this block's fields are not stored and read as zero
      cur_next.mode = bus_req.wdata & CMIBS_MODE_MASK;
    end

    if (bus_req.rd)
    begin
      case (bus_req.addr)
        CMIBS_MODE_OFS:
        begin
          cur_next.rdata = cur_reg.mode;
        end
        CMIBS_STAT_OFS:
        begin
          cur_next.rdata = status_word;
        end
        default:
        begin
          cur_next.rdata = '0;
        end
      endcase
    end

    // Software may drop stale requests by writing ones to the status word
    cur_next.act  = act_nxt;
    cur_next.pend = pend_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_reg.mode  <= CMIBS_MODE_RST;
      cur_reg.pend  <= '0;
      cur_reg.act   <= '0;
      cur_reg.rdata <= '0;
      cur_reg.disp  <= 1'b0;
      cur_reg.vec   <= '0;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // Each select is wired from its own mode bit alone; no other mode
  // bit, interrupt state or bus input feeds it.
  generate
    for (genvar g = 0; g < CMIBS_NUM_BANK; g++)
    begin : g_bank
      assign bank_vec[g] = cur_reg.mode[CMIBS_BANK_BIT[g]];
    end
  endgenerate

  assign bank_sel =
    cmibs_bank_sel_s'(bank_vec);

  assign bus_rdata                = cur_reg.rdata;
  assign irq_dispatch             = cur_reg.disp;
  assign irq_dispatch_vec         = cur_reg.vec;
  assign irq_in_service           = |cur_reg.act;
  assign global_maskable_irq_gate = cur_reg.mode[CMIBS_IRQ_GATE_BIT];
  assign irq_nesting_allow        = cur_reg.mode[CMIBS_NEST_BIT];

endmodule // cmibs_mode_ctrl

`default_nettype wire

// ---- bench/cmibs_checker.sv ----
`default_nettype none
module cmibs_checker
  import cmibs_pkg::*;
(
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire cmibs_bus_req_s           bus_req,
  input wire logic [CMIBS_DATA_W-1:0]  bus_rdata,
  input wire logic [CMIBS_NUM_IRQ-1:0] irq_raise,
  input wire logic [CMIBS_NUM_IRQ-1:0] irq_unmask,
  input wire logic                     isr_return,
  input wire logic                     irq_dispatch,
  input wire logic [CMIBS_IDX_W-1:0]   irq_dispatch_vec,
  input wire logic                     irq_in_service,
  input wire logic                     global_maskable_irq_gate,
  input wire logic                     irq_nesting_allow,
  input wire cmibs_bank_sel_s          bank_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CMIBS_NUM_IRQ-1:0] unm_reg;
  always_ff @(posedge clk_sys) unm_reg <= irq_unmask;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence mode_wr_s;
    bus_req.wr && bus_req.addr == CMIBS_MODE_OFS;
  endsequence
  sequence mode_rd_s;
    bus_req.rd && bus_req.addr == CMIBS_MODE_OFS;
  endsequence
  gate_blocks_a: assert property (
    irq_dispatch |-> $past(global_maskable_irq_gate))
    else $error("dispatch with gate closed");
  unmask_needed_a: assert property (
    irq_dispatch |-> unm_reg[irq_dispatch_vec])
    else $error("dispatch of masked source");
  no_preempt_a: assert property (
    irq_dispatch && !$past(irq_nesting_allow) && !$past(isr_return)
    |-> !$past(irq_in_service)) else $error("handler preempted");
  disp_service_a: assert property (
    irq_dispatch |-> irq_in_service) else $error("dispatch not in service");
  mode_write_a: assert property (
    mode_wr_s |=> {global_maskable_irq_gate, irq_nesting_allow, bank_sel}
    == {$past(bus_req.wdata[12:10]), $past(bus_req.wdata[7:3])})
    else $error("mode outputs differ from write");
  mode_read_a: assert property (
    mode_rd_s |=> bus_rdata == {19'h0, $past(global_maskable_irq_gate),
    $past(irq_nesting_allow), $past(bank_sel[5]), 2'h0,
    $past(bank_sel[4:0]), 3'h0}) else $error("mode readback wrong");
  rdata_idle_a: assert property (
    !bus_req.rd |=> bus_rdata == '0) else $error("read data not idle");
  unmapped_rd_a: assert property (
    bus_req.rd && bus_req.addr != CMIBS_MODE_OFS
    && bus_req.addr != CMIBS_STAT_OFS |=> bus_rdata == '0)
    else $error("unmapped read not zero");
endmodule // cmibs_checker
bind cmibs_mode_ctrl cmibs_checker u_chk (
  .clk_sys                  (clk_sys),
  .rst_n                    (rst_n),
  .bus_req                  (bus_req),
  .bus_rdata                (bus_rdata),
  .irq_raise                (irq_raise),
  .irq_unmask               (irq_unmask),
  .isr_return               (isr_return),
  .irq_dispatch             (irq_dispatch),
  .irq_dispatch_vec         (irq_dispatch_vec),
  .irq_in_service           (irq_in_service),
  .global_maskable_irq_gate (global_maskable_irq_gate),
  .irq_nesting_allow        (irq_nesting_allow),
  .bank_sel                 (bank_sel)
);
`default_nettype wire

// ---- bench/core_mode_irq_and_bank_select_bench.sv ----
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: value mismatch", $time); end end
module core_mode_irq_and_bank_select_bench
  import cmibs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk_sys;
  logic                     rst_n;
  cmibs_bus_req_s           bus_req;
  logic [CMIBS_DATA_W-1:0]  bus_rdata;
  logic [CMIBS_NUM_IRQ-1:0] irq_raise;
  logic [CMIBS_NUM_IRQ-1:0] irq_unmask;
  logic                     isr_return;
  logic                     irq_dispatch;
  logic [CMIBS_IDX_W-1:0]   irq_dispatch_vec;
  logic                     irq_in_service;
  logic                     global_maskable_irq_gate;
  logic                     irq_nesting_allow;
  cmibs_bank_sel_s          bank_sel;
  logic [7:0]               outs;
  int                       fails = 0;
  int                       n_checks = 0;
  logic [31:0]              rows [6][2] = '{'{32'hFFFFFFFF, 32'h00001CF8},
    '{32'h00001000, 32'h00001000}, '{32'h00000848, 32'h00000848},
    '{32'h00000490, 32'h00000490}, '{32'h00000027, 32'h00000020},
    '{32'h00000000, 32'h00000000}};
  assign outs = {global_maskable_irq_gate, irq_nesting_allow, bank_sel};
  cmibs_mode_ctrl dut (
    .clk_sys                  (clk_sys),
    .rst_n                    (rst_n),
    .bus_req                  (bus_req),
    .bus_rdata                (bus_rdata),
    .irq_raise                (irq_raise),
    .irq_unmask               (irq_unmask),
    .isr_return               (isr_return),
    .irq_dispatch             (irq_dispatch),
    .irq_dispatch_vec         (irq_dispatch_vec),
    .irq_in_service           (irq_in_service),
    .global_maskable_irq_gate (global_maskable_irq_gate),
    .irq_nesting_allow        (irq_nesting_allow),
    .bank_sel                 (bank_sel)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    `CHK(bus_rdata, e)
  endtask
  task automatic pulse(input logic [7:0] r, input logic t,
                       input logic [7:0] m);
    @(posedge clk_sys);
    irq_raise <= r;
    isr_return <= t;
    irq_unmask <= m;
    @(posedge clk_sys);
    irq_raise <= '0;
    isr_return <= 1'b0;
  endtask
  // Only the first dispatch in the window counts
  task automatic disp(input logic d, input logic [2:0] v);
    logic       seen;
    logic [2:0] got;
    seen = 1'b0;
    got = '0;
    repeat (6)
    begin
      @(negedge clk_sys);
      if (irq_dispatch === 1'b1 && seen === 1'b0)
      begin
        seen = 1'b1;
        got = irq_dispatch_vec;
      end
    end
    `CHK(seen, d)
    if (d) `CHK(got, v)
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    logic [31:0] e;
    rst_n = 1'b0;
    bus_req = '0;
    irq_raise = '0;
    irq_unmask = '0;
    isr_return = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(CMIBS_MODE_OFS, 32'h0);
    rd(CMIBS_STAT_OFS, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      e = rows[i][1];
      wr(CMIBS_MODE_OFS, rows[i][0]);
      rd(CMIBS_MODE_OFS, e);
      `CHK(outs, {e[12:10], e[7:3]})
    end
    wr(8'h10, 32'hFFFFFFFF);
    rd(CMIBS_MODE_OFS, 32'h0);
    rd(8'h08, 32'h0);
    $display("register tests done");
    pulse(8'h06, 1'b0, 8'h64);
    disp(1'b0, 3'h0);
    wr(CMIBS_MODE_OFS, 32'h1000);
    disp(1'b1, 3'h2);
    pulse(8'h00, 1'b0, 8'h66);
    disp(1'b0, 3'h0);
    pulse(8'h00, 1'b1, 8'h66);
    disp(1'b1, 3'h1);
    pulse(8'h00, 1'b1, 8'h66);
    disp(1'b0, 3'h0);
    `CHK(irq_in_service, 1'b0)
    wr(CMIBS_MODE_OFS, 32'h1800);
    pulse(8'h20, 1'b0, 8'h6E);
    disp(1'b1, 3'h5);
    pulse(8'h08, 1'b0, 8'h6E);
    disp(1'b1, 3'h3);
    pulse(8'h40, 1'b0, 8'h6E);
    disp(1'b0, 3'h0);
    rd(CMIBS_STAT_OFS, 32'h00002840);
    pulse(8'h00, 1'b1, 8'h6E);
    disp(1'b0, 3'h0);
    pulse(8'h00, 1'b1, 8'h6E);
    disp(1'b1, 3'h6);
    $display("interrupt tests done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    `CHK({irq_in_service, irq_dispatch, irq_dispatch_vec, outs}, 13'h0)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(CMIBS_MODE_OFS, 32'h0);
    pulse(8'h80, 1'b0, 8'h00);
    rd(CMIBS_STAT_OFS, 32'h00000080);
    wr(CMIBS_STAT_OFS, 32'h00000080);
    rd(CMIBS_STAT_OFS, 32'h0);
    $display("reset and status tests done");
    report_and_stop();
  end
endmodule // core_mode_irq_and_bank_select_bench
`default_nettype wire
